// ===== rtl/bace_pkg.sv
// Constants for the branch address and cycle count encoder.
// Assumes one trace clock and a byte-wide stream sink.
package bace_pkg;

  // ----------------------------------------------------------------
  // Instruction alignment states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BACE_ST_WORD,
    BACE_ST_HALF,
    BACE_ST_BYTECODE
  } bace_isa_e;

  // ----------------------------------------------------------------
  // Byte field positions and widths
  // ----------------------------------------------------------------
  localparam int          BACE_CONT_BIT      = 7;
  localparam int          BACE_EXC_FLAG_BIT  = 6;
  localparam int          BACE_ADDR_MAX_B    = 5;
  localparam int          BACE_CC_MAX_B      = 5;
  localparam int          BACE_EXC_NUM_W     = 9;
  localparam int          BACE_CC_W          = 32;
  localparam logic [31:0] BACE_CC_OVERFLOW   = 32'hFFFF_FFFF;
  localparam logic [2:0]  BACE_WORD_TAG      = 3'h1;
  localparam logic [1:0]  BACE_HALF_TAG      = 2'h1;
  localparam logic [31:0] BACE_ADDR_RESET    = 32'h0000_0000;
  localparam logic        BACE_FIRST_CC_TOP_ADDR = 1'b0;
  localparam logic        BACE_FIRST_CC_TOP_SYNC = 1'b1;

endpackage : bace_pkg

// ===== rtl/bace_encoder.sv
// Branch address packet body encoder: address, exception info and cycle count.
// Assumes the header byte is sent elsewhere and that the sink takes one byte per
// cycle under out_ready; all inputs come from logic on ref_clk.
//
// Overview of operation
// - Exception info forces at least two address bytes
// - Second exception byte: virt flag, exc[8:4]
// - First exception byte layout with continuation flag
// - Word state drives alternate set flag zero
// - Alignment change without exception sends five bytes
// - Half state, high bits changed: five bytes
// - Fewest cycle count bytes holding the value
// - First count byte top bit by packet type
// - Continuation flags, seven bits per later byte
// - Cycle count only when cycle-accurate enabled
// - Address byte continuation and exception flag
// - Drop leading unchanged address bytes
// - All ones count marks counter overflow
`timescale 1ns/10ps
module bace_encoder
  import bace_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  input  wire logic                 clk_en,
  input  wire logic                 cycle_accurate_en,
  input  wire logic                 pkt_valid,
  output logic                      pkt_ready,
  input  wire logic                 pkt_is_sync,
  input  wire logic [31:0]          pkt_addr,
  input  wire bace_pkg::bace_isa_e  pkt_isa,
  input  wire logic                 pkt_exc_valid,
  input  wire logic [8:0]           pkt_exc_num,
  input  wire logic                 alternate_instruction_set_flag,
  input  wire logic                 security_world_flag,
  input  wire logic                 pkt_virt_flag,
  input  wire logic [31:0]          pkt_cycle_count,
  input  wire logic                 pkt_cc_overflow,
  output logic                      out_valid,
  output logic [7:0]                out_byte,
  output logic                      out_last,
  input  wire logic                 out_ready
);
  import bace_pkg::*;

  // ----------------------------------------------------------------
  // Byte buffer for one packet body
  // ----------------------------------------------------------------
  localparam int NB = BACE_ADDR_MAX_B + 2 + BACE_CC_MAX_B;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Length and index registers are four bits wide, so the longest
  // body must still fit below sixteen bytes
  if (NB > 15) begin : g_nb_check
    $error("body buffer too deep for four-bit index");
  end

  // Count byte slicing covers exactly a 32-bit cycle count
  if (BACE_CC_W != 32) begin : g_cc_check
    $error("cycle count width must be 32");
  end

  // Address byte images assume five bytes at most
  if (BACE_ADDR_MAX_B != 5) begin : g_addr_check
    $error("address section must be five bytes at most");
  end

  logic [7:0]        buf_q [NB];
  logic [3:0]        len_q;
  logic [3:0]        idx_q;
  logic              busy_q;
  logic [31:0]       ref_addr_q;
  bace_isa_e         ref_isa_q;
  logic              ref_valid_q;

  logic [7:0]        bld   [NB];
  logic [3:0]        bld_len;

  // Number of address bytes the changed MSB needs for a given state.
  // Halfword state shifts every boundary down one bit, because byte 0
  // starts at address bit 1 instead of bit 2.
  function automatic logic [2:0] addr_bytes(input logic [31:0] diff,
                                            input bace_isa_e   isa);
    logic [2:0] n;
    n = 3'd1;
    if (isa == BACE_ST_HALF) begin
      if (|diff[31:27])      n = 3'd5;
      else if (|diff[26:20]) n = 3'd4;
      else if (|diff[19:13]) n = 3'd3;
      else if (|diff[12:7])  n = 3'd2;
    end else begin
      if (|diff[31:28])      n = 3'd5;
      else if (|diff[27:21]) n = 3'd4;
      else if (|diff[20:14]) n = 3'd3;
      else if (|diff[13:8])  n = 3'd2;
    end
    return n;
  endfunction : addr_bytes

  // Fewest cycle count bytes for a value
  function automatic logic [2:0] cc_bytes(input logic [31:0] c);
    logic [2:0] n;
    n = 3'd1;
    if (|c[31:25])      n = 3'd5;
    else if (|c[24:18]) n = 3'd4;
    else if (|c[17:11]) n = 3'd3;
    else if (|c[10:4])  n = 3'd2;
    return n;
  endfunction : cc_bytes

  // ----------------------------------------------------------------
  // Packet body builder
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0]  na;
    logic [2:0]  nc;
    logic        two_exc;
    logic [31:0] cc;
    logic [31:0] a;
    logic [3:0]  p;
    logic [3:0]  pa;
    logic [7:0]  abyte [BACE_ADDR_MAX_B];
    na      = 3'd1;
    nc      = 3'd1;
    two_exc = 1'b0;
    cc      = 32'h0000_0000;
    a       = pkt_addr;
    p       = 4'h0;
    pa      = 4'h0;
    for (int i = 0; i < NB; i++) begin
      bld[i] = 8'h00;
    end
    for (int i = 0; i < BACE_ADDR_MAX_B; i++) begin
      abyte[i] = 8'h00;
    end
    // Address length: full after reset or on an alignment change,
    // otherwise up to the highest bit that differs from the reference
    if (!ref_valid_q) begin
      na = 3'd5;
    end else if (ref_isa_q != pkt_isa) begin
      na = 3'd5;
    end else begin
      na = addr_bytes(pkt_addr ^ ref_addr_q, pkt_isa);
    end
    // Byte 0 has no room for the exception flag, so a second byte is kept
    if (pkt_exc_valid && na < 3'd2) begin
      na = 3'd2;
    end

    // Images of all five address bytes; only the first na are sent
    if (pkt_isa == BACE_ST_HALF) begin
      abyte[0][6:0] = {a[6:1], 1'b1};
      abyte[1][5:0] = a[12:7];
      abyte[1][6]   = a[13];
      abyte[2][6:0] = a[20:14];
      abyte[3][6:0] = a[27:21];
      abyte[4][6:0] = {1'b0, BACE_HALF_TAG, a[31:28]};
    end else begin
      abyte[0][6:0] = {a[7:2], 1'b0};
      abyte[1][6:0] = a[14:8];
      abyte[2][6:0] = a[21:15];
      abyte[3][6:0] = a[28:22];
      abyte[4][6:0] = {1'b0, BACE_WORD_TAG, a[31:29]};
    end

    // Continuation on every address byte but the last; the last byte
    // from byte 1 upward also says whether exception info follows
    for (int i = 0; i < BACE_ADDR_MAX_B; i++) begin
      if (i < int'(na)) begin
        bld[i] = abyte[i];
        bld[i][BACE_CONT_BIT] = (i < int'(na) - 1);
        if (i == int'(na) - 1 && i > 0) begin
          bld[i][BACE_EXC_FLAG_BIT] = pkt_exc_valid;
        end
      end
    end

    // Write pointer continues after the address section
    pa = {1'b0, na};
    p  = pa;

    // Second exception byte only when its contents are not all zero
    if (pkt_exc_valid) begin
      two_exc = (pkt_exc_num[8:4] != 5'h00) || pkt_virt_flag;
      bld[p] = {two_exc,
                (pkt_isa == BACE_ST_WORD) ? 1'b0
                  : alternate_instruction_set_flag,
                1'b0, pkt_exc_num[3:0], security_world_flag};
      p = 4'(p + 4'h1);
      if (two_exc) begin
        bld[p] = {1'b0, pkt_virt_flag, 1'b0, pkt_exc_num[8:4]};
        p = 4'(p + 4'h1);
      end
    end

    // Leading-zero compressed count, least significant bits first
    if (cycle_accurate_en) begin
      cc = pkt_cc_overflow ? BACE_CC_OVERFLOW : pkt_cycle_count;
      nc = cc_bytes(cc);
      bld[p] = {pkt_is_sync ? BACE_FIRST_CC_TOP_SYNC
                            : BACE_FIRST_CC_TOP_ADDR,
                (nc > 3'd1), cc[3:0], 2'b00};
      for (int k = 1; k < BACE_CC_MAX_B; k++) begin
        if (k < int'(nc)) begin
          bld[4'(int'(p) + k)] = {(k < int'(nc) - 1),
                                  cc[4 + 7*(k-1) +: 7]};
        end
      end
      p = 4'(p + {1'b0, nc});
    end
    bld_len = p;
  end

  // ----------------------------------------------------------------
  // Packet acceptance and byte sequencing
  // ----------------------------------------------------------------
  // A body is taken only while idle; each consumed byte but the last advances idx,
  // and the final consumed byte returns the encoder to idle
  wire accept    = clk_en && pkt_valid && pkt_ready;
  wire step      = clk_en && busy_q && out_ready;
  wire last_step = step && (idx_q == 4'(len_q - 4'h1));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q    <= 1'b0;
      len_q     <= 4'h0;
      idx_q     <= 4'h0;
      pkt_ready <= 1'b0;
    end else if (clk_en) begin
      if (accept) begin
        busy_q    <= 1'b1;
        len_q     <= bld_len;
        idx_q     <= 4'h0;
        pkt_ready <= 1'b0;
      end else if (last_step) begin
        busy_q    <= 1'b0;
        pkt_ready <= 1'b1;
      end else if (step) begin
        idx_q <= 4'(idx_q + 4'h1);
      end else if (!busy_q) begin
        pkt_ready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NB; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (accept) begin
      buf_q <= bld;
    end
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  // Tracks the byte under idx; byte 0 comes straight from the builder
  // so the first byte stands one cycle after acceptance
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_byte  <= 8'h00;
      out_last  <= 1'b0;
    end else if (clk_en) begin
      if (accept) begin
        out_valid <= 1'b1;
        out_byte  <= bld[0];
        out_last  <= (bld_len == 4'h1);
      end else if (last_step) begin
        out_valid <= 1'b0;
        out_last  <= 1'b0;
      end else if (step) begin
        out_byte <= buf_q[4'(idx_q + 4'h1)];
        out_last <= (4'(idx_q + 4'h2) == len_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // Compression reference
  // ----------------------------------------------------------------
  // Updated at acceptance so the next body compares against this one
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_addr_q  <= BACE_ADDR_RESET;
      ref_isa_q   <= BACE_ST_WORD;
      ref_valid_q <= 1'b0;
    end else if (accept) begin
      ref_addr_q  <= pkt_addr;
      ref_isa_q   <= pkt_isa;
      ref_valid_q <= 1'b1;
    end
  end

endmodule : bace_encoder

// ===== bench/bace_encoder_asserts.sv
// Stream checks for the branch address body encoder.
// Assumes a bind onto bace_encoder.
`timescale 1ns/10ps
module bace_encoder_asserts (
  input logic       ref_clk,
  input logic       arst_n,
  input logic       clk_en,
  input logic       cycle_accurate_en,
  input logic       pkt_valid,
  input logic       pkt_ready,
  input logic       pkt_exc_valid,
  input logic       pkt_cc_overflow,
  input logic       out_valid,
  input logic [7:0] out_byte,
  input logic       out_last,
  input logic       out_ready
);
  logic [3:0] n_q;
  logic       cc_q;
  logic       ex_q;
  logic       ov_q;
  wire        go = pkt_valid && pkt_ready && clk_en;
  wire        tk = out_valid && out_ready && clk_en;
  // ----
  // Packet context and byte index
  // ----
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      n_q  <= 4'h0;
      cc_q <= 1'b0;
      ex_q <= 1'b0;
      ov_q <= 1'b0;
    end else if (go) begin
      n_q  <= 4'h0;
      cc_q <= cycle_accurate_en;
      ex_q <= pkt_exc_valid;
      ov_q <= pkt_cc_overflow;
    end else if (tk) begin
      n_q <= n_q + 4'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  chk_accept_answer: assert property (go |=> out_valid && !pkt_ready)
    else $error("no byte after accept");
  chk_byte_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
    else $error("byte changed while stalled");
  chk_idle_quiet: assert property (pkt_ready |-> !out_valid)
    else $error("byte while idle");
  chk_ready_after: assert property (tk && out_last |=> !out_valid ##[0:1] pkt_ready)
    else $error("no return to idle");
  chk_two_addr: assert property (out_valid && ex_q && n_q == 4'h0 |-> out_byte[7])
    else $error("single address byte with exception");
  chk_plain_tail: assert property (out_valid && out_last && !cc_q |-> !out_byte[7])
    else $error("last byte flags more");
  chk_no_count: assert property (out_valid && out_last && !cc_q && !ex_q |-> n_q < 4'h5)
    else $error("count bytes while disabled");
  chk_ovf_tail: assert property (out_valid && out_last && cc_q && ov_q |-> out_byte == 8'h7F)
    else $error("overflow tail wrong");
endmodule : bace_encoder_asserts
bind bace_encoder bace_encoder_asserts chk_u (
  .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
  .cycle_accurate_en(cycle_accurate_en), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
  .pkt_exc_valid(pkt_exc_valid), .pkt_cc_overflow(pkt_cc_overflow),
  .out_valid(out_valid), .out_byte(out_byte), .out_last(out_last), .out_ready(out_ready)
);

// ===== bench/bace_sink.sv
// Capture model for the trace byte stream.
// Assumes bytes move on out_valid and out_ready together.
`timescale 1ns/10ps
module bace_sink (
  input  logic       ref_clk,
  input  logic       arst_n,
  input  logic       slow,
  input  logic       out_valid,
  input  logic [7:0] out_byte,
  input  logic       out_last,
  output logic       out_ready
);
  logic [7:0] got[$];
  int         pkts;
  logic [1:0] ph_q;
  // ----
  // Stall pattern and capture
  // ----
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_q      <= 2'h0;
      out_ready <= 1'b0;
      pkts      <= 0;
    end else begin
      ph_q      <= ph_q + 2'h1;
      out_ready <= !slow || ph_q == 2'h3;
      if (out_valid && out_ready) begin
        got.push_back(out_byte);
        if (out_last) pkts <= pkts + 1;
      end
    end
  end
endmodule : bace_sink

// ===== bench/bace_encoder_bench.sv
// Directed bench for the branch address body encoder.
// Assumes the package, encoder, sink model and checker are compiled first.
`timescale 1ns/10ps
module bace_encoder_bench;
  import bace_pkg::*;
  logic ref_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, cycle_accurate_en = 1'b0;
  logic pkt_valid = 1'b0, pkt_is_sync = 1'b0, pkt_exc_valid = 1'b0, pkt_cc_overflow = 1'b0;
  logic alternate_instruction_set_flag = 1'b0, security_world_flag = 1'b0;
  logic pkt_virt_flag = 1'b0, slow = 1'b0, pkt_ready, out_valid, out_last, out_ready;
  logic [31:0] pkt_addr = '0, pkt_cycle_count = '0, v;
  logic [8:0]  pkt_exc_num = '0;
  logic [7:0]  out_byte;
  bace_isa_e   pkt_isa = BACE_ST_WORD;
  int          failures = 0, checks = 0, i, j;
  bace_encoder dut_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .cycle_accurate_en(cycle_accurate_en), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .pkt_is_sync(pkt_is_sync), .pkt_addr(pkt_addr), .pkt_isa(pkt_isa),
    .pkt_exc_valid(pkt_exc_valid), .pkt_exc_num(pkt_exc_num),
    .alternate_instruction_set_flag(alternate_instruction_set_flag),
    .security_world_flag(security_world_flag), .pkt_virt_flag(pkt_virt_flag),
    .pkt_cycle_count(pkt_cycle_count), .pkt_cc_overflow(pkt_cc_overflow),
    .out_valid(out_valid), .out_byte(out_byte), .out_last(out_last), .out_ready(out_ready)
  );
  bace_sink    s_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .slow(slow), .out_valid(out_valid),
    .out_byte(out_byte), .out_last(out_last), .out_ready(out_ready)
  );
  // ----
  // Helpers
  // ----
  task automatic test_done();
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tmo(input int t);
    if (t >= 80) begin
      failures++;
      test_done();
    end
  endtask : tmo
  function automatic logic [7:0] ccb(input logic [31:0] c, input int n, input int k);
    if (n == 0)
      return {1'b0, k > 1, c[3:0], 2'b00};
    return {n < k - 1, c[7*n-3 +: 7]};
  endfunction : ccb
  task automatic pkt(input logic [31:0] a, input bace_isa_e s, input logic [8:0] e = '0,
                     input logic x = 0, vt = 0, sy = 0, ov = 0, input logic [31:0] c = '0);
    int t;
    int p;
    @(posedge ref_clk);
    s_u.got.delete();
    p = s_u.pkts;
    pkt_addr <= a;
    pkt_isa <= s;
    pkt_exc_num <= e;
    pkt_exc_valid <= x;
    alternate_instruction_set_flag <= x;
    security_world_flag <= x;
    pkt_virt_flag <= vt;
    pkt_is_sync <= sy;
    pkt_cc_overflow <= ov;
    pkt_cycle_count <= c;
    pkt_valid <= 1'b1;
    @(negedge ref_clk);
    for (t = 0; t < 80 && pkt_ready !== 1'b1; t++) @(negedge ref_clk);
    tmo(t);
    @(posedge ref_clk);
    pkt_valid <= 1'b0;
    for (t = 0; t < 80 && s_u.pkts == p; t++) @(negedge ref_clk);
    tmo(t);
  endtask : pkt
  // ----
  // Sequence
  // ----
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    pkt(32'h0000_1000, BACE_ST_WORD);
    chk(s_u.got.size(), 5);
    chk(s_u.got[4][7], 0);
    pkt(32'h0000_1008, BACE_ST_WORD);
    chk(s_u.got.size(), 1);
    pkt(32'h0000_1000, BACE_ST_WORD, 9'h005, 1'b1);
    chk(s_u.got.size(), 3);
    chk(s_u.got[1][7:6], 2'h1);
    chk(s_u.got[2], 8'h0B);
    @(posedge ref_clk) slow <= 1'b1;
    pkt(32'h0000_1000, BACE_ST_WORD, 9'h1A3, 1'b1, 1'b1);
    chk(s_u.got.size(), 4);
    chk(s_u.got[2], 8'h87);
    chk(s_u.got[3][7:6], 2'h1);
    pkt(32'h0000_1000, BACE_ST_HALF);
    pkt(32'h0000_1000, BACE_ST_WORD);
    chk(s_u.got.size(), 5);
    pkt(32'h0000_1000, BACE_ST_HALF);
    pkt(32'hF800_1000, BACE_ST_HALF, 9'h005, 1'b1);
    chk(s_u.got.size(), 6);
    chk(s_u.got[4][7:6], 2'h1);
    @(posedge ref_clk) cycle_accurate_en <= 1'b1;
    pkt(32'h0000_1000, BACE_ST_WORD);
    chk(s_u.got[5], 8'h00);
    for (i = 0; i < 5; i++) begin
      v = 32'h0000_0005 << (7 * i);
      pkt(32'h0000_1000, BACE_ST_WORD, '0, 0, 0, 0, 0, v);
      chk(s_u.got.size(), i + 2);
      for (j = 0; j <= i; j++)
        chk(s_u.got[j + 1], ccb(v, j, i + 1));
    end
    pkt(32'h0000_1000, BACE_ST_WORD, '0, 0, 0, 0, 1'b1, 32'h0000_0005);
    chk(s_u.got.size(), 6);
    chk(s_u.got[5], 8'h7F);
    pkt(32'h0000_1000, BACE_ST_WORD, '0, 0, 0, 1'b1, 0, 32'h0000_0005);
    chk(s_u.got[s_u.got.size() - 1], 8'h94);
    test_done();
  end
endmodule : bace_encoder_bench
